// ---- rtl/analog_threshold_comparator.v ----
`timescale 1ns/1ns
`include "threshold_comparator_defines.vh"
// Summary of operation
// RL1 - five modes, one held per instance
// RL2 - operands from analog, timer or counter
// RL3 - first operand times first gain
// RL4 - second operand times second gain
// RL5 - offset added to first operand
// RL6 - hysteresis forms upper and lower thresholds
// RL7 - signed 32-bit arithmetic throughout
// RL8 - unconfigured gain means no multiplication
// RL9 - display shows values above 9999 minus 10000
// RL10 - analog samples are unsigned 10-bit
// RL11 - inclusive modes also switch on equality
// RL12 - less: on below, off above upper
// RL13 - less-equal: on at/below, off above upper
// RL14 - equal: on at setpoint, off outside band
// RL15 - greater-equal: on at/above, off below lower
// RL16 - greater: on reaching, off below lower
// RL17 - visibility flag lists parameters in menu
// RL18 - configurer should use hysteresis of 20+
// RL19 - either operand may be a constant setpoint
// RL20 - evaluated per scan, holds between, reset clears
module analog_threshold_comparator (
  // clock and reset
  input wire CLK,
  input wire RESET_N,
  // scan strobe from the program sequencer
  input wire SCAN_STROBE,
  // analog channels a..d, 10 bits each
  input wire [39:0] ANALOG_CHANNELS,
  // timer and counter actual values, 16 x 16 bits
  input wire [255:0] TIMER_ACTUAL_VALUES,
  input wire [255:0] COUNTER_ACTUAL_VALUES,
  // axi4-lite slave
  input wire [11:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output reg S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output reg S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [11:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output reg S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY,
  // contact and menu visibility
  output reg COMPARE_CONTACT,
  output reg MENU_VISIBLE
);

// ----------------------------------------
// configuration registers, scan results and contact state
// ----------------------------------------
reg [31:0] control_r;
reg [31:0] sel_r;
reg [13:0] first_gain_r;
reg [13:0] second_gain_r;
reg [13:0] operand_offset_r;
reg [13:0] hysteresis_width_r;
reg [13:0] first_setpoint_r;
reg [13:0] second_setpoint_r;
reg signed [31:0] first_value_r;
reg signed [31:0] second_value_r;
reg [31:0] display_r;
reg contact_r;

wire [2:0] mode = control_r[`CTRL_MODE_MSB:`CTRL_MODE_LSB]; // [RL1]
wire [1:0] src1 = sel_r[`SEL_SRC_MSB:0];
wire [3:0] idx1 = sel_r[`SEL_IDX_MSB:`SEL_IDX_LSB];
wire [1:0] src2 = sel_r[`SEL_SECOND_LSB+`SEL_SRC_MSB:`SEL_SECOND_LSB];
wire [3:0] idx2 = sel_r[`SEL_SECOND_LSB+`SEL_IDX_MSB:`SEL_SECOND_LSB+`SEL_IDX_LSB];

// ----------------------------------------
// operand selection
// ----------------------------------------
wire [9:0] analog_w [0:3];
wire [15:0] timer_w [0:15];
wire [15:0] counter_w [0:15];
genvar g;
generate
  for (g = 0; g < 16; g = g + 1) begin : unpack
    if (g < 4) begin : ana
      assign analog_w[g] = ANALOG_CHANNELS[g*10 +: 10]; // [RL10]
    end
    assign timer_w[g] = TIMER_ACTUAL_VALUES[g*16 +: 16];
    assign counter_w[g] = COUNTER_ACTUAL_VALUES[g*16 +: 16];
  end
endgenerate

function [31:0] pick;
  input [1:0] src;
  input [3:0] idx;
  input [13:0] setpoint;
  begin
    case (src) // [RL2]
      `SRC_ANALOG: pick = {22'h000000, analog_w[idx[1:0]]};
      `SRC_TIMER: pick = {16'h0000, timer_w[idx]};
      `SRC_COUNTER: pick = {16'h0000, counter_w[idx]};
      default: pick = {18'h00000, setpoint}; // [RL19]
    endcase
  end
endfunction

// ----------------------------------------
// scaling arithmetic
// ----------------------------------------
wire [31:0] raw1 = pick(src1, idx1, first_setpoint_r);
wire [31:0] raw2 = pick(src2, idx2, second_setpoint_r);
wire [63:0] prod1 = raw1 * {18'h00000, first_gain_r};
wire [63:0] prod2 = raw2 * {18'h00000, second_gain_r};
// products of 16-bit values by 9999 stay far below 2^31
wire [31:0] scaled1 = control_r[`CTRL_GAIN1_SET_BIT] ? prod1[31:0] : raw1; // [RL3] [RL8] [RL7]
wire [31:0] scaled2 = control_r[`CTRL_GAIN2_SET_BIT] ? prod2[31:0] : raw2; // [RL4] [RL8] [RL7]
wire signed [31:0] v1 = scaled1 + {18'h00000, operand_offset_r}; // [RL5]
wire signed [31:0] v2 = scaled2;
wire signed [31:0] hy = {18'h00000, hysteresis_width_r};
wire signed [31:0] upper = v2 + hy; // [RL6]
wire signed [31:0] lower = v2 - hy; // [RL6]

// ----------------------------------------
// threshold compare
// ----------------------------------------
// each mode reduces to one switch-on and one switch-off condition
wire below_second = v1 < v2;
wire at_second = v1 == v2;
wire above_second = v1 > v2;
wire above_upper = v1 > upper; // [RL6]
wire below_lower = v1 < lower; // [RL6]
reg turn_on;
reg turn_off;
always @* begin
  turn_on = 1'b0;
  turn_off = 1'b1;
  case (mode)
    `MODE_LESS: begin
      turn_on = below_second; // [RL12]
      turn_off = above_upper;
    end
    `MODE_LESS_EQUAL: begin
      turn_on = below_second | at_second; // [RL13] [RL11]
      turn_off = above_upper;
    end
    `MODE_EQUAL: begin
      turn_on = at_second; // [RL14]
      turn_off = above_upper | below_lower;
    end
    `MODE_GREATER_EQUAL: begin
      turn_on = above_second | at_second; // [RL15] [RL11]
      turn_off = below_lower;
    end
    `MODE_GREATER: begin
      // "reaches" read as strictly above for the strict mode
      turn_on = above_second; // [RL16]
      turn_off = below_lower;
    end
    default: begin
      // unused mode codes park the contact off
      turn_on = 1'b0;
      turn_off = 1'b1;
    end
  endcase
end

// on wins over off; between the thresholds nothing fires
reg contact_nxt;
always @* begin
  contact_nxt = contact_r; // hold inside the band [RL20]
  if (turn_on) contact_nxt = 1'b1;
  else if (turn_off) contact_nxt = 1'b0;
end

// ----------------------------------------
// operand display
// ----------------------------------------
// display copy of the scaled first operand before the offset is added, compare path untouched
wire [31:0] disp_nxt = (scaled1 > {18'h00000, `PARAM_MAX}) ?
  scaled1 - `DISPLAY_WRAP : scaled1; // [RL9]

// ----------------------------------------
// per-scan latch
// ----------------------------------------
always @(posedge CLK or negedge RESET_N) begin
  if (!RESET_N) begin
    contact_r <= 1'b0;
    first_value_r <= 32'h00000000;
    second_value_r <= 32'h00000000;
    display_r <= 32'h00000000;
  end else if (SCAN_STROBE) begin
    contact_r <= contact_nxt; // [RL20]
    first_value_r <= v1;
    second_value_r <= v2;
    display_r <= disp_nxt;
  end
end

// ----------------------------------------
// axi4-lite write channel
// ----------------------------------------
reg aw_held_r;
reg w_held_r;
reg [11:0] awaddr_r;
reg [31:0] wdata_r;
wire aw_ok = aw_held_r | (S_AXI_AWVALID & S_AXI_AWREADY);
wire w_ok = w_held_r | (S_AXI_WVALID & S_AXI_WREADY);
wire [11:0] wa = aw_held_r ? awaddr_r : S_AXI_AWADDR;
wire [31:0] wd = w_held_r ? wdata_r : S_AXI_WDATA;
wire do_write = aw_ok & w_ok & ~S_AXI_BVALID;
// status and value words are read-only; a write there answers with an error
wire wmapped = (wa == `OFS_CONTROL) | (wa == `OFS_OPERAND_SEL) |
  (wa == `OFS_FIRST_GAIN) | (wa == `OFS_SECOND_GAIN) |
  (wa == `OFS_OPERAND_OFFSET) | (wa == `OFS_HYSTERESIS) | (wa == `OFS_SETPOINTS);

function [13:0] clip;
  input [13:0] v;
  begin
    clip = (v > `PARAM_MAX) ? `PARAM_MAX : v;
  end
endfunction

always @(posedge CLK or negedge RESET_N) begin
  if (!RESET_N) begin
    S_AXI_AWREADY <= 1'b0;
    S_AXI_WREADY <= 1'b0;
    S_AXI_BVALID <= 1'b0;
    S_AXI_BRESP <= `AXI_OKAY;
    aw_held_r <= 1'b0;
    w_held_r <= 1'b0;
    awaddr_r <= 12'h000;
    wdata_r <= 32'h00000000;
    control_r <= `CONTROL_RESET;
    sel_r <= `SEL_RESET;
    first_gain_r <= `PARAM_RESET;
    second_gain_r <= `PARAM_RESET;
    operand_offset_r <= `PARAM_RESET;
    hysteresis_width_r <= `PARAM_RESET;
    first_setpoint_r <= `PARAM_RESET;
    second_setpoint_r <= `PARAM_RESET;
  end else begin
    // ready idles as a pulse every other cycle; a held valid waits one edge at most
    S_AXI_AWREADY <= ~aw_ok & ~S_AXI_AWREADY & ~S_AXI_BVALID;
    S_AXI_WREADY <= ~w_ok & ~S_AXI_WREADY & ~S_AXI_BVALID;
    if (S_AXI_AWVALID & S_AXI_AWREADY) begin
      aw_held_r <= 1'b1;
      awaddr_r <= S_AXI_AWADDR;
    end
    if (S_AXI_WVALID & S_AXI_WREADY) begin
      w_held_r <= 1'b1;
      wdata_r <= S_AXI_WDATA;
    end
    if (S_AXI_BVALID & S_AXI_BREADY) S_AXI_BVALID <= 1'b0;
    if (do_write) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= wmapped ? `AXI_OKAY : `AXI_SLVERR;
      // whole-word writes only; partial strobes leave registers as they are
      if (S_AXI_WSTRB == 4'hf) begin
        case (wa)
          `OFS_CONTROL: control_r <= {26'h0000000, wd[5:0]};
          `OFS_OPERAND_SEL: sel_r <= {18'h00000, wd[13:8], 2'h0, wd[5:0]};
          `OFS_FIRST_GAIN: first_gain_r <= clip(wd[13:0]);
          `OFS_SECOND_GAIN: second_gain_r <= clip(wd[13:0]);
          `OFS_OPERAND_OFFSET: operand_offset_r <= clip(wd[13:0]);
          `OFS_HYSTERESIS: hysteresis_width_r <= clip(wd[13:0]);
          `OFS_SETPOINTS: begin
            first_setpoint_r <= clip(wd[13:0]);
            second_setpoint_r <= clip(wd[29:16]);
          end
          default: ;
        endcase
      end
    end
  end
end

// ----------------------------------------
// axi4-lite read channel
// ----------------------------------------
reg [31:0] rd_nxt;
reg rd_ok;
always @* begin
  rd_ok = 1'b1;
  case (S_AXI_ARADDR)
    `OFS_CONTROL: rd_nxt = control_r;
    `OFS_OPERAND_SEL: rd_nxt = sel_r;
    `OFS_FIRST_GAIN: rd_nxt = {18'h00000, first_gain_r};
    `OFS_SECOND_GAIN: rd_nxt = {18'h00000, second_gain_r};
    `OFS_OPERAND_OFFSET: rd_nxt = {18'h00000, operand_offset_r};
    `OFS_HYSTERESIS: rd_nxt = {18'h00000, hysteresis_width_r};
    `OFS_SETPOINTS: rd_nxt = {2'h0, second_setpoint_r, 2'h0, first_setpoint_r};
    `OFS_STATUS: rd_nxt = {31'h00000000, contact_r};
    `OFS_FIRST_VALUE: rd_nxt = first_value_r;
    `OFS_SECOND_VALUE: rd_nxt = second_value_r;
    `OFS_DISPLAY: rd_nxt = display_r;
    default: begin
      rd_nxt = 32'h00000000;
      rd_ok = 1'b0;
    end
  endcase
end

always @(posedge CLK or negedge RESET_N) begin
  if (!RESET_N) begin
    S_AXI_ARREADY <= 1'b0;
    S_AXI_RVALID <= 1'b0;
    S_AXI_RDATA <= 32'h00000000;
    S_AXI_RRESP <= `AXI_OKAY;
  end else begin
    // one read in flight: ready stays low while a response waits
    S_AXI_ARREADY <= ~S_AXI_ARREADY & ~S_AXI_RVALID & S_AXI_ARVALID;
    if (S_AXI_ARVALID & S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_nxt;
      S_AXI_RRESP <= rd_ok ? `AXI_OKAY : `AXI_SLVERR;
    end else if (S_AXI_RVALID & S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end
end

// ----------------------------------------
// output flops
// ----------------------------------------
always @(posedge CLK or negedge RESET_N) begin
  if (!RESET_N) begin
    COMPARE_CONTACT <= 1'b0;
    MENU_VISIBLE <= 1'b1;
  end else begin
    COMPARE_CONTACT <= contact_r;
    MENU_VISIBLE <= control_r[`CTRL_VISIBLE_BIT]; // [RL17]
  end
end

endmodule // analog_threshold_comparator

// ---- rtl/threshold_comparator_defines.vh ----
`ifndef THRESHOLD_COMPARATOR_DEFINES_VH
`define THRESHOLD_COMPARATOR_DEFINES_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CONTROL 12'h000
`define OFS_OPERAND_SEL 12'h004
`define OFS_FIRST_GAIN 12'h008
`define OFS_SECOND_GAIN 12'h00c
`define OFS_OPERAND_OFFSET 12'h010
`define OFS_HYSTERESIS 12'h014
`define OFS_SETPOINTS 12'h018
`define OFS_STATUS 12'h01c
`define OFS_FIRST_VALUE 12'h020
`define OFS_SECOND_VALUE 12'h024
`define OFS_DISPLAY 12'h028
// ----------------------------------------
// field positions
// ----------------------------------------
`define CTRL_MODE_LSB 0
`define CTRL_MODE_MSB 2
`define CTRL_VISIBLE_BIT 3
`define CTRL_GAIN1_SET_BIT 4
`define CTRL_GAIN2_SET_BIT 5
`define SEL_SRC_MSB 1
`define SEL_IDX_LSB 2
`define SEL_IDX_MSB 5
`define SEL_SECOND_LSB 8
// ----------------------------------------
// source and mode codes
// ----------------------------------------
`define SRC_ANALOG 2'h0
`define SRC_TIMER 2'h1
`define SRC_COUNTER 2'h2
`define SRC_SETPOINT 2'h3
`define MODE_LESS 3'h0
`define MODE_LESS_EQUAL 3'h1
`define MODE_EQUAL 3'h2
`define MODE_GREATER_EQUAL 3'h3
`define MODE_GREATER 3'h4
// ----------------------------------------
// limits and reset values
// ----------------------------------------
`define PARAM_MAX 14'h270f
`define DISPLAY_WRAP 32'h00002710
`define CONTROL_RESET 32'h00000008
`define SEL_RESET 32'h00000000
`define PARAM_RESET 14'h0000
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`endif

// ---- test/scan_source.sv ----
`timescale 1ns/1ns
module scan_source (
  // clock and reset
  input wire CLK,
  input wire RESET_N,
  // scan request and next samples
  input wire req,
  input wire [39:0] samples,
  // toward the comparator
  output reg [39:0] ANALOG_CHANNELS,
  output reg SCAN_STROBE
);
  // ----
  // converter and scan sequencer
  // ----
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ANALOG_CHANNELS <= 40'h0;
      SCAN_STROBE <= 1'b0;
    end else begin
      // samples refresh only on a scan request, at the edge that raises the strobe
      if (req) ANALOG_CHANNELS <= samples;
      SCAN_STROBE <= req;
    end
  end
endmodule // scan_source

// ---- test/comparator_chk.sv ----
`timescale 1ns/1ns
module comparator_chk (
  // clock, reset and scan
  input wire CLK,
  input wire RESET_N,
  input wire SCAN_STROBE,
  input wire COMPARE_CONTACT,
  // register bus
  input wire S_AXI_AWVALID,
  input wire S_AXI_AWREADY,
  input wire S_AXI_WVALID,
  input wire S_AXI_WREADY,
  input wire S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire S_AXI_ARVALID,
  input wire S_AXI_ARREADY,
  input wire [31:0] S_AXI_RDATA,
  input wire [1:0] S_AXI_RRESP,
  input wire S_AXI_RVALID,
  input wire S_AXI_RREADY
);
  // ----
  // properties
  // ----
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);
  sequence s_wr_take;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence s_rd_take;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  a_contact_hold: assert property (!$past(SCAN_STROBE, 2) |-> $stable(COMPARE_CONTACT))
    else $error("contact moved without scan");
  a_write_answer: assert property (s_wr_take |=> S_AXI_BVALID)
    else $error("no write response");
  a_write_quiet: assert property (s_wr_take |=> (!S_AXI_AWREADY && !S_AXI_WREADY) [*2])
    else $error("write ready early");
  a_read_answer: assert property (s_rd_take |=> S_AXI_RVALID && !S_AXI_ARREADY)
    else $error("no read response");
  a_write_refused: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write taken while busy");
  a_write_done: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write response stuck");
  a_read_done: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
    else $error("read response stuck");
  a_error_data: assert property (S_AXI_RVALID && S_AXI_RRESP == 2'h2 |-> S_AXI_RDATA == 32'h0)
    else $error("error read with data");
endmodule // comparator_chk

// ---- test/tb_analog_threshold_comparator.sv ----
`timescale 1ns/1ns
`include "threshold_comparator_defines.vh"
module tb_analog_threshold_comparator;
  logic CLK, RESET_N, SCAN_STROBE, COMPARE_CONTACT, MENU_VISIBLE, scan_req, p;
  logic [39:0] ANALOG_CHANNELS, samples;
  logic [255:0] TIMER_ACTUAL_VALUES, COUNTER_ACTUAL_VALUES;
  logic [11:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID;
  logic S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  logic [33:0] exq[$];
  int seed = 32'hb285;
  int fails = 0;
  int compares = 0;
  int v;
  analog_threshold_comparator i_dut (.CLK(CLK), .RESET_N(RESET_N), .SCAN_STROBE(SCAN_STROBE),
    .ANALOG_CHANNELS(ANALOG_CHANNELS), .TIMER_ACTUAL_VALUES(TIMER_ACTUAL_VALUES),
    .COUNTER_ACTUAL_VALUES(COUNTER_ACTUAL_VALUES), .S_AXI_AWADDR(S_AXI_AWADDR),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
    .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY), .COMPARE_CONTACT(COMPARE_CONTACT),
    .MENU_VISIBLE(MENU_VISIBLE));
  scan_source i_src (.CLK(CLK), .RESET_N(RESET_N), .req(scan_req), .samples(samples),
    .ANALOG_CHANNELS(ANALOG_CHANNELS), .SCAN_STROBE(SCAN_STROBE));
  // ----
  // tasks
  // ----
  task automatic check(input string name, input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // one transfer; w picks write, e is the expected response and data
  task automatic bus(input bit w, input logic [11:0] a, input logic [31:0] d,
      input logic [33:0] e);
    int n;
    n = 0;
    exq.push_back(e);
    S_AXI_AWADDR <= a;
    S_AXI_ARADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= w;
    S_AXI_WVALID <= w;
    S_AXI_BREADY <= w;
    S_AXI_ARVALID <= !w;
    S_AXI_RREADY <= !w;
    do begin
      @(posedge CLK);
      n++;
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (!S_AXI_BVALID && !S_AXI_RVALID && n < 100);
    if (!S_AXI_BVALID && !S_AXI_RVALID) fails++; // no answer within the limit
    S_AXI_BREADY <= 1'b0;
    S_AXI_RREADY <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic scan(input logic [9:0] a);
    samples <= {30'($random(seed)), a};
    scan_req <= 1'b1;
    @(posedge CLK);
    scan_req <= 1'b0;
    repeat (2) @(posedge CLK);
  endtask
  // setpoint 100, hysteresis 25
  function automatic logic nxt(input int m, input int a, input logic q);
    case (m)
      0: nxt = a < 100 ? 1 : a > 125 ? 0 : q;
      1: nxt = a <= 100 ? 1 : a > 125 ? 0 : q;
      2: nxt = a == 100 ? 1 : (a > 125 || a < 75) ? 0 : q;
      3: nxt = a >= 100 ? 1 : a < 75 ? 0 : q;
      default: nxt = a > 100 ? 1 : a < 75 ? 0 : q;
    endcase
  endfunction
  // ----
  // clock, monitor, watchdog
  // ----
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    if (S_AXI_BVALID && S_AXI_BREADY) check("bresp", {S_AXI_BRESP, 32'h0}, exq.pop_front());
    if (S_AXI_RVALID && S_AXI_RREADY) check("rdata", {S_AXI_RRESP, S_AXI_RDATA}, exq.pop_front());
  end
  initial begin
    repeat (20000) @(posedge CLK);
    fails++;
    complete_run;
  end
  // ----
  // scenarios
  // ----
  initial begin
    {RESET_N, scan_req, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID} = 6'h0;
    {S_AXI_RREADY, S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, samples, p} = 0;
    S_AXI_WSTRB = 4'hf;
    TIMER_ACTUAL_VALUES = {8{$random(seed)}};
    COUNTER_ACTUAL_VALUES = {8{$random(seed)}};
    repeat (3) @(posedge CLK);
    RESET_N <= 1'b1;
    bus(0, `OFS_CONTROL, 0, {`AXI_OKAY, `CONTROL_RESET});
    check("menu", MENU_VISIBLE, 1);
    check("contact", COMPARE_CONTACT, 0);
    bus(1, 12'hffc, 0, {`AXI_SLVERR, 32'h0});
    bus(0, 12'hffc, 0, {`AXI_SLVERR, 32'h0});
    bus(1, `OFS_FIRST_GAIN, 32'hffff, 0);
    bus(0, `OFS_FIRST_GAIN, 0, {20'h0, `PARAM_MAX});
    $display("registers done");
    bus(1, `OFS_OPERAND_SEL, 32'h300, 0);
    bus(1, `OFS_SETPOINTS, 32'h00640000, 0);
    bus(1, `OFS_HYSTERESIS, 32'd25, 0);
    for (int m = 0; m < 5; m++) begin
      bus(1, `OFS_CONTROL, 32'h8 | m, 0);
      for (int k = 0; k < 40; k++) begin
        v = (k == 0) ? 0 : 60 + $unsigned($random(seed)) % 81;
        scan(v[9:0]);
        p = nxt(m, v, p);
        bus(0, `OFS_STATUS, 0, {33'h0, p});
        check("contact", COMPARE_CONTACT, p);
      end
    end
    $display("modes done");
    bus(1, `OFS_CONTROL, 32'h38, 0);
    bus(1, `OFS_FIRST_GAIN, 32'd3, 0);
    bus(1, `OFS_SECOND_GAIN, 32'd2, 0);
    bus(1, `OFS_OPERAND_OFFSET, 32'd7, 0);
    scan(10'd500);
    bus(0, `OFS_FIRST_VALUE, 0, 34'd1507);
    bus(0, `OFS_SECOND_VALUE, 0, 34'd200);
    bus(0, `OFS_DISPLAY, 0, 34'd1500);
    bus(1, `OFS_CONTROL, 32'h8, 0);
    scan(10'd500);
    bus(0, `OFS_FIRST_VALUE, 0, 34'd507);
    bus(0, `OFS_SECOND_VALUE, 0, 34'd100);
    TIMER_ACTUAL_VALUES[95:80] <= 16'd1234;
    COUNTER_ACTUAL_VALUES[255:240] <= 16'd10233;
    bus(1, `OFS_OPERAND_SEL, 32'h315, 0);
    scan(0);
    bus(0, `OFS_FIRST_VALUE, 0, 34'd1241);
    bus(1, `OFS_OPERAND_SEL, 32'h33e, 0);
    scan(0);
    bus(0, `OFS_FIRST_VALUE, 0, 34'd10240);
    bus(0, `OFS_DISPLAY, 0, 34'd233);
    bus(1, `OFS_OPERAND_SEL, 32'h303, 0);
    bus(1, `OFS_SETPOINTS, 32'h0064270f, 0);
    bus(1, `OFS_FIRST_GAIN, 32'd9999, 0);
    bus(1, `OFS_CONTROL, 32'h10, 0);
    scan(0);
    bus(0, `OFS_FIRST_VALUE, 0, 34'd99980008);
    check("menu", MENU_VISIBLE, 0);
    $display("scaling done");
    complete_run;
  end
endmodule // tb_analog_threshold_comparator
bind analog_threshold_comparator comparator_chk i_chk (.CLK(CLK), .RESET_N(RESET_N),
  .SCAN_STROBE(SCAN_STROBE), .COMPARE_CONTACT(COMPARE_CONTACT), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY));
